// [pbsp_port.sv]
// pipelined burst memory port, two-stage read and write pipeline
// assumes controller on mclk; pins other than output_enable_n pass two flops first
// Notes on behaviour
// RULE_01 - synchronous inputs captured on rising edge
// RULE_02 - read data leaves through output registers
// RULE_03 - qualifier high freezes all state
// RULE_04 - back-to-back reads and writes, no idles
// RULE_05 - drivers off during write data phase
// RULE_06 - two low-active lane selects steer writes
// RULE_07 - write completes internally, no extra pulse
// RULE_08 - three chip selects gate every access; code samples them only on load cycles, advance cycles ignore them
// RULE_09 - address picks one of all words
// RULE_10 - low address bits load burst counter
// RULE_11 - low write strobe starts a write
// RULE_12 - order select picks linear or interleaved
// RULE_13 - eighteen-bit shared data lines
// RULE_14 - async output enable gates drivers
// RULE_15 - selects active low, high, low
// RULE_16 - advance steps counter, low loads address
// RULE_17 - drivers off in write, deselect, first cycle
// RULE_18 - sleep input idles, keeps stored data
// RULE_19 - data two qualified edges after address
// RULE_20 - each lane covers nine data lines
`timescale 1ns/10ps
`include "pbsp_defines.svh"
module pbsp_port #(
   parameter int AW = `PBSP_ADDR_W,
   parameter int DW = `PBSP_DATA_W,
   parameter int NL = `PBSP_LANES,
   parameter int DEPTH = `PBSP_DEPTH
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clock_qualifier_n,
   input wire logic chip_select_first_n,
   input wire logic chip_select_second,
   input wire logic chip_select_third_n,
   input wire logic write_strobe_n,
   input wire logic [NL-1:0] byte_lane_select_n,
   input wire logic advance_or_load,
   input wire logic [AW-1:0] addr,
   input wire logic burst_order_linear,
   input wire logic output_enable_n,
   input wire logic sleep_request,
   input wire logic [DW-1:0] data_in,
   output logic [DW-1:0] data_out,
   output logic data_oe,
   output logic asleep
);
   ////////////////////////////////////////////////////////////////////
   // pin synchronisers
   localparam int SW = 8 + NL + AW + DW;
   logic [SW-1:0] s1_r, s2_r;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s1_r <= '0;
         s2_r <= {1'b1, 2'b10, 1'b1, 1'b1, {NL{1'b1}}, {(AW+DW+3){1'b0}}};
      end else begin
         s1_r <= {clock_qualifier_n, chip_select_first_n,
                  chip_select_second, chip_select_third_n,
                  write_strobe_n, byte_lane_select_n, advance_or_load,
                  burst_order_linear, sleep_request, addr, data_in};
         s2_r <= s1_r;
      end
   end
   logic q_n, cs1_n, cs2, cs3_n, we_n, adv, lin, slp;
   logic [NL-1:0] bl_n;
   logic [AW-1:0] a_s;
   logic [DW-1:0] d_s;
   assign {q_n, cs1_n, cs2, cs3_n, we_n, bl_n, adv, lin, slp, a_s, d_s}
      = s2_r;

   ////////////////////////////////////////////////////////////////////
   // burst order
   function automatic logic [1:0] burst_next(input logic [1:0] start,
                                             input logic [1:0] cnt,
                                             input logic linear);
      logic [1:0] r;
      r = linear ? start + cnt : start ^ cnt;
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // command stages
   logic go;
   logic sel;
   assign go = !q_n && !slp; // see RULE_03 see RULE_18
   assign sel = !cs1_n && cs2 && !cs3_n; // see RULE_08 see RULE_15

   pbsp_pkg::pbsp_cmd_s st1_r, st1_nxt, st2_r, st2_nxt;
   logic [AW-1:0] base_r, base_nxt;
   logic [1:0] cnt_r, cnt_nxt;
   pbsp_pkg::pbsp_op_e bop_r, bop_nxt;
   logic first_r, first_nxt;
   logic [DW-1:0] dout_r, dout_nxt;
   logic rd_v_r, rd_v_nxt;
   logic [DW-1:0] rd_data;
   logic [DW-1:0] rd_word;

   always_comb begin
      st1_nxt = st1_r;
      st2_nxt = st2_r;
      base_nxt = base_r;
      cnt_nxt = cnt_r;
      bop_nxt = bop_r;
      first_nxt = first_r;
      dout_nxt = dout_r;
      rd_v_nxt = rd_v_r;
      if (go) begin // see RULE_03
         st2_nxt = st1_r; // see RULE_19
         dout_nxt = rd_word; // see RULE_02
         rd_v_nxt = (st1_r.op == pbsp_pkg::PBSP_READ);
         first_nxt = (st2_r.op == pbsp_pkg::PBSP_IDLE); // see RULE_17
         st1_nxt.lane_n = bl_n; // see RULE_01
         if (!adv) begin // see RULE_16
            if (sel) begin
               base_nxt = a_s; // see RULE_09 see RULE_10
               cnt_nxt = 2'h0;
               // see RULE_11
               bop_nxt = we_n ? pbsp_pkg::PBSP_READ
                              : pbsp_pkg::PBSP_WRITE;
            end else begin
               bop_nxt = pbsp_pkg::PBSP_IDLE;
            end
            st1_nxt.op = bop_nxt;
            st1_nxt.addr = bop_nxt == pbsp_pkg::PBSP_IDLE ? st1_r.addr : a_s;
         end else begin
            cnt_nxt = cnt_r + 2'h1; // see RULE_16
            st1_nxt.op = bop_r;
            st1_nxt.addr = {base_r[AW-1:2],
                            burst_next(base_r[1:0], cnt_nxt, lin)};
            // see RULE_12
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st1_r <= '{op: pbsp_pkg::PBSP_IDLE, addr: '0, lane_n: '1};
         st2_r <= '{op: pbsp_pkg::PBSP_IDLE, addr: '0, lane_n: '1};
         base_r <= '0;
         cnt_r <= 2'h0;
         bop_r <= pbsp_pkg::PBSP_IDLE;
         first_r <= 1'b1;
         dout_r <= '0;
         rd_v_r <= 1'b0;
      end else begin
         st1_r <= st1_nxt;
         st2_r <= st2_nxt;
         base_r <= base_nxt;
         cnt_r <= cnt_nxt;
         bop_r <= bop_nxt;
         first_r <= first_nxt;
         dout_r <= dout_nxt;
         rd_v_r <= rd_v_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // storage; write in data phase, read addressed one stage ahead
   localparam int LW = DW / NL;
   logic wr_now;
   assign wr_now = go && (st2_r.op == pbsp_pkg::PBSP_WRITE); // see RULE_07
   // same-word write one stage ahead forwards its lanes
   always_comb begin
      rd_word = rd_data;
      if (wr_now && st2_r.addr == st1_r.addr) begin // see RULE_04
         for (int i = 0; i < NL; i++) begin
            if (!st2_r.lane_n[i]) begin // see RULE_06
               rd_word[i*LW +: LW] = d_s[i*LW +: LW];
            end
         end
      end
   end

   pbsp_store #(
      .DEPTH(DEPTH),
      .AW(AW),
      .LW(LW),
      .NL(NL)
   ) u_store (
      .mclk(mclk),
      .wr_en(wr_now),
      .wr_lane_n(st2_r.lane_n),
      .wr_addr(st2_r.addr),
      .rd_addr(st1_r.addr), // see RULE_04
      .wr_data(d_s),
      .rd_data(rd_data)
   );

   ////////////////////////////////////////////////////////////////////
   // output drivers
   assign data_out = dout_r; // see RULE_13
   // async enable combined with synchronous drive control
   assign data_oe = !output_enable_n && rd_v_r && !first_r; // see RULE_14
   // see RULE_05 see RULE_17
   assign asleep = slp;
endmodule

// [pbsp_defines.svh]
// width and layout constants for the burst memory port
// assumes inclusion by bare name from package and modules
`ifndef PBSP_DEFINES_SVH
`define PBSP_DEFINES_SVH
`define PBSP_ADDR_W 18
`define PBSP_DATA_W 18
`define PBSP_LANE_W 9
`define PBSP_LANES 2
`define PBSP_DEPTH 262144
`define PBSP_BURST_W 2
`endif

// [pbsp_pkg.sv]
// types shared by the burst memory port
// assumes pbsp_defines.svh on the include path
`include "pbsp_defines.svh"
package pbsp_pkg;
   typedef enum logic [1:0] {
      PBSP_IDLE,
      PBSP_READ,
      PBSP_WRITE
   } pbsp_op_e;
   typedef struct packed {
      pbsp_op_e op;
      logic [`PBSP_ADDR_W-1:0] addr;
      logic [`PBSP_LANES-1:0] lane_n;
   } pbsp_cmd_s;
endpackage

// [pbsp_store.sv]
// word storage with per-lane write and combinational read
// assumes single clock mclk; enables come from the port logic
`timescale 1ns/10ps
`include "pbsp_defines.svh"
module pbsp_store #(
   parameter int DEPTH = `PBSP_DEPTH,
   parameter int AW = `PBSP_ADDR_W,
   parameter int LW = `PBSP_LANE_W,
   parameter int NL = `PBSP_LANES
) (
   input wire logic mclk,
   input wire logic wr_en,
   input wire logic [NL-1:0] wr_lane_n,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [AW-1:0] rd_addr,
   input wire logic [NL*LW-1:0] wr_data,
   output logic [NL*LW-1:0] rd_data
);
   logic [NL*LW-1:0] mem [DEPTH];
   // lane-gated write, self-timed in one edge
   always_ff @(posedge mclk) begin
      if (wr_en) begin
         for (int i = 0; i < NL; i++) begin
            if (!wr_lane_n[i]) begin // see RULE_06 see RULE_20
               mem[wr_addr][i*LW +: LW] <= wr_data[i*LW +: LW];
            end
         end
      end
   end
   assign rd_data = mem[rd_addr];
endmodule

// [pbsp_port_monitor.sv]
// pin-level checks on the burst memory port
// assumes bind into pbsp_port, one clock, pins other than output_enable_n pass two sync flops
`timescale 1ns/10ps
module pbsp_port_monitor #(parameter int DW = 18) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clock_qualifier_n,
   input wire logic chip_select_first_n,
   input wire logic chip_select_second,
   input wire logic chip_select_third_n,
   input wire logic write_strobe_n,
   input wire logic advance_or_load,
   input wire logic output_enable_n,
   input wire logic sleep_request,
   input wire logic [DW-1:0] data_out,
   input wire logic data_oe,
   input wire logic asleep
);
   default clocking @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   wire logic go = !clock_qualifier_n && !sleep_request;
   wire logic sel = !chip_select_first_n && chip_select_second &&
      !chip_select_third_n;
   wire logic wr = go && sel && !advance_or_load && !write_strobe_n;
   wire logic rd = go && sel && !advance_or_load && write_strobe_n;
   property p_oe; output_enable_n |-> !data_oe; endproperty
   a_oe: assert property (p_oe) else $error("oe off but driving");
   property p_frz; clock_qualifier_n [*5] |-> $stable(data_out); endproperty
   a_frz: assert property (p_frz) else $error("moved while held");
   property p_slp; sleep_request [*5] |-> $stable(data_oe); endproperty
   a_slp: assert property (p_slp) else $error("moved in sleep");
   property p_asl; $stable(sleep_request) [*4] |-> asleep == sleep_request;
   endproperty
   a_asl: assert property (p_asl) else $error("asleep wrong");
   property p_wr; wr |-> ##4 !data_oe; endproperty
   a_wr: assert property (p_wr) else $error("drove in write");
   property p_des; go && !sel |-> ##4 !data_oe ##1 !data_oe; endproperty
   a_des: assert property (p_des) else $error("drove deselected");
   property p_rd; rd && $past(sel) ##4 !output_enable_n |-> data_oe;
   endproperty
   a_rd: assert property (p_rd) else $error("read not driven");
   property p_b2b; wr ##1 rd |-> ##3 !data_oe ##1 (data_oe || output_enable_n);
   endproperty
   a_b2b: assert property (p_b2b) else $error("turnaround wrong");
endmodule
bind pbsp_port pbsp_port_monitor #(.DW(DW)) u_mon (.mclk, .rst_n,
   .clock_qualifier_n, .chip_select_first_n, .chip_select_second,
   .chip_select_third_n, .write_strobe_n, .advance_or_load, .output_enable_n,
   .sleep_request, .data_out, .data_oe, .asleep);

// [pbsp_ctrl_model.sv]
// controller model: selects and strobe decoded from the command, write data two edges late
// assumes commands from the bench, changed just after mclk rises
`timescale 1ns/10ps
module pbsp_ctrl_model (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic qn,
   input wire pbsp_pkg::pbsp_cmd_s cmd,
   input wire logic [17:0] wdata,
   output logic cs1_n,
   output logic cs2,
   output logic cs3_n,
   output logic we_n,
   output logic [17:0] data_in
);
   logic idle;
   logic [1:0] v_r;
   logic [17:0] d1_r;
   logic [17:0] d2_r;
   assign idle = cmd.op == pbsp_pkg::PBSP_IDLE;
   assign cs1_n = idle && cmd.addr[0];
   assign cs2 = !(idle && cmd.addr[1]);
   assign cs3_n = idle && cmd.addr[1:0] == 2'h0;
   assign we_n = cmd.op != pbsp_pkg::PBSP_WRITE;
   assign data_in = v_r[1] ? d2_r : ~d2_r;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         v_r <= 2'h0;
         d1_r <= 18'h0;
         d2_r <= 18'h0;
      end else if (!qn) begin
         v_r <= {v_r[0], !we_n};
         d1_r <= wdata;
         if (v_r[0]) d2_r <= d1_r;
      end
   end
endmodule

// [tb.sv]
// self-checking bench for the burst memory port
// assumes pbsp_pkg, pbsp_port and pbsp_ctrl_model compiled first
`timescale 1ns/10ps
module tb;
   logic mclk = 1'h0, rst_n = 1'h0, qn = 1'h0, adv = 1'h0, lin = 1'h1;
   logic oen = 1'h0, slp = 1'h0, frz = 1'h0, cur_rd = 1'h0, cur_act = 1'h0;
   logic cs1_n, cs2, cs3_n, we_n, data_oe;
   logic [17:0] wdata = 18'h0, cur_d = 18'h0, data_in, data_out, a;
   logic [4:0] srd = 5'h0, sact = 5'h0;
   logic [4:0][17:0] sd;
   logic [17:0] ref_m [logic [17:0]];
   int err_count = 0, cmp_count = 0;
   pbsp_pkg::pbsp_cmd_s cmd = '0;
   pbsp_ctrl_model u_ctl (.mclk, .rst_n, .qn, .cmd, .wdata, .cs1_n, .cs2,
      .cs3_n, .we_n, .data_in);
   pbsp_port dut (.mclk, .rst_n, .clock_qualifier_n(qn),
      .chip_select_first_n(cs1_n), .chip_select_second(cs2),
      .chip_select_third_n(cs3_n), .write_strobe_n(we_n),
      .byte_lane_select_n(cmd.lane_n), .advance_or_load(adv),
      .addr(cmd.addr), .burst_order_linear(lin), .output_enable_n(oen),
      .sleep_request(slp), .data_in, .data_out, .data_oe, .asleep());
   initial forever #25 mclk = ~mclk;
   function automatic logic [17:0] bur(logic [17:0] s, int n, logic l);
      bur = {s[17:2], l ? s[1:0] + 2'(n) : s[1:0] ^ 2'(n)};
   endfunction
   task automatic chk(string nm, logic [17:0] e, logic [17:0] g);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic issue(pbsp_pkg::pbsp_op_e op, logic [17:0] ad,
         logic [1:0] ln, logic st);
      logic [17:0] w;
      w = 18'($urandom);
      @(posedge mclk);
      cmd <= '{op, ad, ln};
      adv <= st;
      wdata <= w;
      cur_rd <= op == pbsp_pkg::PBSP_READ && !frz;
      cur_act <= op != pbsp_pkg::PBSP_IDLE && !frz;
      cur_d <= ref_m.exists(ad) ? ref_m[ad] : 18'h0;
      if (op == pbsp_pkg::PBSP_WRITE && !frz) begin
         if (!ln[0]) ref_m[ad][8:0] = w[8:0];
         if (!ln[1]) ref_m[ad][17:9] = w[17:9];
      end
   endtask
   task automatic print_verdict();
      if (err_count == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   always @(posedge mclk) begin
      srd <= {srd[3:0], cur_rd};
      sact <= {sact[3:0], cur_act};
      sd <= {sd[3:0], cur_d};
   end
   always @(negedge mclk) if (rst_n) begin
      chk("data_oe", 18'(srd[3] && sact[4] && !oen), 18'(data_oe));
      if (srd[3]) chk("data_out", sd[3], data_out);
   end
   initial begin
      void'($urandom(29316));
      repeat (12) @(posedge mclk);
      rst_n <= 1'h1;
      for (int i = 0; i < 16; i++) begin
         a = {{14{i[3]}}, 4'(i)};
         issue(pbsp_pkg::PBSP_WRITE, a, 2'h0, 1'h0);
      end
      for (int f = 0; f < 2; f++) begin
         repeat (6) issue(pbsp_pkg::PBSP_IDLE, 18'h1, 2'h3, 1'h0);
         frz = 1'h1;
         if (f == 0) qn <= 1'h1;
         else slp <= 1'h1;
         repeat (4) issue(pbsp_pkg::PBSP_IDLE, 18'h2, 2'h3, 1'h0);
         repeat (8) issue(pbsp_pkg::PBSP_WRITE, 18'h3, 2'h0, 1'h0);
         repeat (4) issue(pbsp_pkg::PBSP_IDLE, 18'h0, 2'h3, 1'h0);
         qn <= 1'h0;
         slp <= 1'h0;
         frz = 1'h0;
      end
      repeat (300) begin
         a = 18'($urandom_range(15));
         a = {{14{a[3]}}, a[3:0]};
         oen <= $urandom_range(7) == 0;
         issue(pbsp_pkg::pbsp_op_e'($urandom_range(2)), a, 2'($urandom),
            1'h0);
      end
      oen <= 1'h0;
      for (int l = 0; l < 2; l++) begin
         repeat (5) issue(pbsp_pkg::PBSP_IDLE, 18'h0, 2'h3, 1'h0);
         lin <= l[0];
         a = {{14{l[0]}}, 4'($urandom)};
         for (int n = 0; n < 4; n++)
            issue(pbsp_pkg::PBSP_WRITE, bur(a, n, l[0]), 2'h0, n > 0);
         for (int n = 0; n < 4; n++)
            issue(pbsp_pkg::PBSP_READ, bur(a, n, l[0]), 2'h0, n > 0);
      end
      repeat (6) issue(pbsp_pkg::PBSP_IDLE, 18'h0, 2'h3, 1'h0);
      print_verdict();
   end
   // about five times the expected run
   initial begin
      #100000;
      err_count++;
      print_verdict();
   end
endmodule
